// *** host_model.sv ***
`timescale 1ns/1ns
// Register host: one request per edge, expected read data kept in order.
module host_model (
  input  wire logic                      ref_clk_i,
  output supply_mon_pkg::reg_req_t       req_o
);
  logic [7:0] exp_q[$];

  initial req_o = '0;

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~req_o.wdata};
    exp_q.push_back(e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
  endtask

  // Released lines show the inverse of their last value.
  task automatic idle();
    @(posedge ref_clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
  endtask

  task automatic rd_pair(input logic [7:0] lo_e, input logic [7:0] hi_e);
    rd(8'h70, lo_e);
    rd(8'h71, hi_e);
    idle();
  endtask
endmodule

// *** supply_mon_pkg.sv ***
package supply_mon_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MEAS_W = 10;

  localparam logic [7:0] MEAS_LOW_OFS     = 8'h70;
  localparam logic [7:0] MEAS_HIGH_OFS    = 8'h71;
  localparam logic [7:0] SNK_DISC_LOW_OFS = 8'h72;
  localparam logic [7:0] SNK_DISC_HIGH_OFS = 8'h73;
  localparam logic [7:0] STOP_DIS_LOW_OFS = 8'h74;
  localparam logic [7:0] STOP_DIS_HIGH_OFS = 8'h75;
  localparam logic [7:0] ALM_HI_LOW_OFS   = 8'h76;
  localparam logic [7:0] ALM_HI_HIGH_OFS  = 8'h77;
  localparam logic [7:0] ALM_LO_LOW_OFS   = 8'h78;
  localparam logic [7:0] ALM_LO_HIGH_OFS  = 8'h79;

  localparam logic [9:0] SNK_DISC_RST = 10'h0A0;
  localparam logic [9:0] STOP_DIS_RST = 10'h01C;
  localparam logic [9:0] ALM_HI_RST   = 10'h000;
  localparam logic [9:0] ALM_LO_RST   = 10'h000;

  localparam int unsigned SAMPLE_HI_LSB  = 0;
  localparam int unsigned DIVISOR_LSB    = 2;
  localparam int unsigned THRESH_HI_BITS = 2;
  localparam int unsigned MEAS_HI_BITS   = 2;

  localparam logic [1:0] DIV_ONE      = 2'h0;
  localparam logic [1:0] DIV_TWO      = 2'h1;
  localparam logic [1:0] DIV_FOUR     = 2'h2;
  localparam logic [1:0] DIV_RESERVED = 2'h3;

  localparam int unsigned STEP_MV = 50;

  typedef struct packed {
    logic       valid;
    logic [1:0] divisor;
    logic [9:0] value;
  } sample_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// *** supply_voltage_monitor_regs.sv ***
`timescale 1ns/1ns
// What this block does
// R1: Host reads the measurement low byte before the high byte.
// R2: Low-byte read snapshots the matching high byte for the next read.
// R3: Measurement is ten bits: low register 7:0, high register bits 1:0.
// R4: High register bits 3:2 give divisor: 00 one, 01 two, 10 four.
// R5: Measurement field holds supply voltage divided by the reported divisor.
// R6: Both measurement registers are read-only and reset to zero.
// R7: Sink-disconnect threshold is writable, ten bits, low byte resets A0.
// R8: Stop-discharge threshold is writable, ten bits, low byte resets 1C.
// R9: High-alarm trip point is writable, ten bits, resets to zero.
// R10: Low-alarm trip point is writable, ten bits, resets to zero.
// R11: Thresholds have 50 mV steps; bit 0 ignored in comparisons.
// R12: Each new sample is compared with both alarm trip points.
module supply_voltage_monitor_regs (
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     soft_reset_i,
  input  wire supply_mon_pkg::reg_req_t req_i,
  input  wire supply_mon_pkg::sample_t  sample_i,
  output logic [7:0]                    rdata_o,
  output logic                          rvalid_o,
  output logic [9:0]                    sink_disconnect_threshold_o,
  output logic [9:0]                    stop_discharge_threshold_o,
  output logic                          alarm_high_o,
  output logic                          alarm_low_o
);

  logic [9:0] meas_r;
  logic [1:0] divisor_r;
  logic [7:0] high_snap_r;
  logic [9:0] snk_val;
  logic [9:0] stop_val;
  logic [9:0] alm_hi_val;
  logic [9:0] alm_lo_val;
  logic [7:0] high_live;
  logic [7:0] rdata_nxt;
  logic       rd_low;

  // The sample is produced on this clock, so it needs no synchroniser.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meas_r    <= 10'h000;
      divisor_r <= 2'h0;
    end else if (soft_reset_i) begin
      meas_r    <= 10'h000;
      divisor_r <= 2'h0;
    end else if (sample_i.valid) begin
      meas_r    <= sample_i.value; // R5
      divisor_r <= sample_i.divisor; // R4
    end
  end

  always_comb begin
    high_live = 8'h00;
    high_live[supply_mon_pkg::SAMPLE_HI_LSB +: 2] = meas_r[9:8]; // R3
    high_live[supply_mon_pkg::DIVISOR_LSB +: 2]   = divisor_r; // R4
  end

  assign rd_low = req_i.rd && req_i.addr == supply_mon_pkg::MEAS_LOW_OFS;

  // A low-byte read freezes the upper bits so the pair stays coherent.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_snap_r <= 8'h00;
    end else if (soft_reset_i) begin
      high_snap_r <= 8'h00;
    end else if (rd_low) begin
      high_snap_r <= high_live; // R2
    end
  end

  thresh_reg #(
    .LOW_OFS   (supply_mon_pkg::SNK_DISC_LOW_OFS),
    .HIGH_OFS  (supply_mon_pkg::SNK_DISC_HIGH_OFS),
    .RESET_VAL (supply_mon_pkg::SNK_DISC_RST)
  ) u_snk ( // R7
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (soft_reset_i),
    .req_i     (req_i),
    .value_o   (snk_val)
  );

  thresh_reg #(
    .LOW_OFS   (supply_mon_pkg::STOP_DIS_LOW_OFS),
    .HIGH_OFS  (supply_mon_pkg::STOP_DIS_HIGH_OFS),
    .RESET_VAL (supply_mon_pkg::STOP_DIS_RST)
  ) u_stop ( // R8
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (soft_reset_i),
    .req_i     (req_i),
    .value_o   (stop_val)
  );

  thresh_reg #(
    .LOW_OFS   (supply_mon_pkg::ALM_HI_LOW_OFS),
    .HIGH_OFS  (supply_mon_pkg::ALM_HI_HIGH_OFS),
    .RESET_VAL (supply_mon_pkg::ALM_HI_RST)
  ) u_alm_hi ( // R9
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (soft_reset_i),
    .req_i     (req_i),
    .value_o   (alm_hi_val)
  );

  thresh_reg #(
    .LOW_OFS   (supply_mon_pkg::ALM_LO_LOW_OFS),
    .HIGH_OFS  (supply_mon_pkg::ALM_LO_HIGH_OFS),
    .RESET_VAL (supply_mon_pkg::ALM_LO_RST)
  ) u_alm_lo ( // R10
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (soft_reset_i),
    .req_i     (req_i),
    .value_o   (alm_lo_val)
  );

  always_comb begin
    case (req_i.addr)
      supply_mon_pkg::MEAS_LOW_OFS:      rdata_nxt = meas_r[7:0]; // R3
      supply_mon_pkg::MEAS_HIGH_OFS:     rdata_nxt = high_snap_r; // R2
      supply_mon_pkg::SNK_DISC_LOW_OFS:  rdata_nxt = snk_val[7:0];
      supply_mon_pkg::SNK_DISC_HIGH_OFS: rdata_nxt = {6'h00, snk_val[9:8]};
      supply_mon_pkg::STOP_DIS_LOW_OFS:  rdata_nxt = stop_val[7:0];
      supply_mon_pkg::STOP_DIS_HIGH_OFS: rdata_nxt = {6'h00, stop_val[9:8]};
      supply_mon_pkg::ALM_HI_LOW_OFS:    rdata_nxt = alm_hi_val[7:0];
      supply_mon_pkg::ALM_HI_HIGH_OFS:   rdata_nxt = {6'h00, alm_hi_val[9:8]};
      supply_mon_pkg::ALM_LO_LOW_OFS:    rdata_nxt = alm_lo_val[7:0];
      supply_mon_pkg::ALM_LO_HIGH_OFS:   rdata_nxt = {6'h00, alm_lo_val[9:8]};
      default:                           rdata_nxt = 8'h00;
    endcase
  end

  // Writes to the measurement offsets decode to nothing and are dropped.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= rdata_nxt; // R6
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sink_disconnect_threshold_o <= supply_mon_pkg::SNK_DISC_RST;
      stop_discharge_threshold_o  <= supply_mon_pkg::STOP_DIS_RST;
    end else begin
      sink_disconnect_threshold_o <= snk_val;
      stop_discharge_threshold_o  <= stop_val;
    end
  end

  // Compare with bit 0 masked off; flags refresh on a new sample and clear on soft reset.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alarm_high_o <= 1'b0;
      alarm_low_o  <= 1'b0;
    end else if (soft_reset_i) begin
      alarm_high_o <= 1'b0;
      alarm_low_o  <= 1'b0;
    end else if (sample_i.valid) begin
      alarm_high_o <= sample_i.value[9:1] > alm_hi_val[9:1]; // R12 R11
      alarm_low_o  <= sample_i.value[9:1] < alm_lo_val[9:1]; // R12 R11
    end
  end

  sequence low_read_s;
    req_i.rd && req_i.addr == supply_mon_pkg::MEAS_LOW_OFS;
  endsequence

  sequence high_read_s;
    req_i.rd && req_i.addr == supply_mon_pkg::MEAS_HIGH_OFS
      && !soft_reset_i;
  endsequence

  snapshot_pair_a: assert property ( // R2
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !soft_reset_i ##0 low_read_s ##1 high_read_s |->
      ##1 rdata_o[1:0] == $past(meas_r[9:8], 2))
    else $error("high byte not from the snapshot");

  meas_readonly_a: assert property ( // R6
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !sample_i.valid && !soft_reset_i |=> meas_r == $past(meas_r))
    else $error("measurement changed without a sample");

  high_reserved_a: assert property ( // R4
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rvalid_o && $past(req_i.addr) == supply_mon_pkg::MEAS_HIGH_OFS
      |-> rdata_o[7:4] == 4'h0)
    else $error("reserved bits set in high byte");

  low_byte_read_a: assert property ( // R3
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    low_read_s |=> rdata_o == $past(meas_r[7:0]))
    else $error("low byte mismatch");

  sample_capture_a: assert property ( // R5
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    sample_i.valid && !soft_reset_i |=> meas_r == $past(sample_i.value)
      && divisor_r == $past(sample_i.divisor))
    else $error("sample not captured");

  snk_write_a: assert property ( // R7
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    req_i.wr && req_i.addr == supply_mon_pkg::SNK_DISC_LOW_OFS
      && !soft_reset_i |=> ##1 sink_disconnect_threshold_o[7:0]
      == $past(req_i.wdata, 2))
    else $error("sink threshold write lost");

  stop_reset_a: assert property ( // R8
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    soft_reset_i |=> ##1 stop_discharge_threshold_o
      == supply_mon_pkg::STOP_DIS_RST)
    else $error("stop threshold not at default");

  alarm_high_a: assert property ( // R9
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    sample_i.valid && !soft_reset_i
      && sample_i.value[9:1] <= alm_hi_val[9:1] |=> !alarm_high_o)
    else $error("spurious high alarm");

  alarm_low_a: assert property ( // R10
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    sample_i.valid && !soft_reset_i
      && sample_i.value[9:1] < alm_lo_val[9:1] |=> alarm_low_o)
    else $error("missed low alarm");

  bit_zero_a: assert property ( // R11
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    sample_i.valid && !soft_reset_i
      && sample_i.value == {alm_hi_val[9:1], 1'b1} |=> !alarm_high_o)
    else $error("bit 0 used in compare");

endmodule

// *** supply_voltage_monitor_regs_tb.sv ***
`timescale 1ns/1ns
module supply_voltage_monitor_regs_tb;
  logic                     ref_clk_i;
  logic                     reset_n_i;
  logic                     soft_reset_i;
  supply_mon_pkg::reg_req_t req;
  supply_mon_pkg::sample_t  sample;
  logic [7:0]               rdata;
  logic                     rvalid;
  logic [9:0]               sink_th;
  logic [9:0]               stop_th;
  logic                     alm_hi;
  logic                     alm_lo;
  int                       err_total;
  int                       num_checks;
  logic [9:0]               th [4];
  logic [9:0]               v;
  logic [9:0]               a;
  logic [9:0]               vals [7];

  host_model host (.ref_clk_i(ref_clk_i), .req_o(req));

  supply_voltage_monitor_regs dut (
    .ref_clk_i                   (ref_clk_i),
    .reset_n_i                   (reset_n_i),
    .soft_reset_i                (soft_reset_i),
    .req_i                       (req),
    .sample_i                    (sample),
    .rdata_o                     (rdata),
    .rvalid_o                    (rvalid),
    .sink_disconnect_threshold_o (sink_th),
    .stop_discharge_threshold_o  (stop_th),
    .alarm_high_o                (alm_hi),
    .alarm_low_o                 (alm_lo)
  );

  task automatic check(input logic [9:0] got, input logic [9:0] exp,
                       input string msg);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic test_done();
    if (host.exp_q.size() != 0) err_total++;
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic read_all();
    for (int i = 0; i < 10; i++) begin
      if (i < 2) host.rd(8'(8'h70 + i), 8'h00);
      else if (i % 2 == 0) host.rd(8'(8'h70 + i), th[(i - 2) / 2][7:0]);
      else host.rd(8'(8'h70 + i), {6'h00, th[(i - 2) / 2][9:8]});
    end
    host.idle();
  endtask

  // The sample is taken one edge after it is driven; alarms follow it.
  task automatic put_sample(input logic [1:0] d, input logic [9:0] val);
    @(posedge ref_clk_i);
    sample <= '{valid: 1'b1, divisor: d, value: val};
    @(posedge ref_clk_i);
    sample <= '{valid: 1'b0, divisor: ~d, value: ~val};
    #1;
    check(10'(alm_hi), 10'(val[9:1] > th[2][9:1]), "high alarm");
    check(10'(alm_lo), 10'(val[9:1] < th[3][9:1]), "low alarm");
  endtask

  always @(negedge ref_clk_i) begin
    if (rvalid === 1'b1) begin
      if (host.exp_q.size() == 0) check(10'h001, 10'h000, "extra read");
      else check({2'h0, rdata}, {2'h0, host.exp_q.pop_front()}, "rdata");
    end
  end

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    #(50 * 5000);
    err_total++;
    test_done();
  end

  initial begin
    reset_n_i = 1'b0;
    soft_reset_i = 1'b0;
    sample = '0;
    err_total = 0;
    num_checks = 0;
    th = '{10'h0A0, 10'h01C, 10'h000, 10'h000};
    vals = '{10'h3FF, 10'h202, 10'h201, 10'h200, 10'h100, 10'h0FF, 10'h000};
    void'($urandom(95));
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    check(sink_th, 10'h0A0, "sink reset");
    check(stop_th, 10'h01C, "stop reset");
    read_all();
    host.rd(8'h7A, 8'h00);
    host.rd(8'h6F, 8'h00);
    host.wr(8'h70, 8'hFF);
    host.wr(8'h71, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      v = 10'($urandom);
      th[i] = v;
      host.wr(8'(8'h72 + 2 * i), v[7:0]);
      host.wr(8'(8'h73 + 2 * i), {6'($urandom), v[9:8]});
    end
    host.idle();
    read_all();
    check(sink_th, th[0], "sink output");
    check(stop_th, th[1], "stop output");
    for (int d = 0; d < 4; d++) begin
      v = 10'($urandom);
      put_sample(2'(d), v);
      host.rd_pair(v[7:0], {4'h0, 2'(d), v[9:8]});
    end
    a = 10'($urandom);
    put_sample(2'h1, a);
    host.rd(8'h70, a[7:0]);
    host.idle();
    put_sample(2'h2, ~a);
    host.rd(8'h71, {4'h0, 2'h1, a[9:8]});
    host.idle();
    host.wr(8'h76, 8'h00);
    host.wr(8'h77, 8'h02);
    host.wr(8'h78, 8'h00);
    host.wr(8'h79, 8'h01);
    host.idle();
    th[2] = 10'h200;
    th[3] = 10'h100;
    for (int i = 0; i < 7; i++) put_sample(2'h0, vals[i]);
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b0;
    th = '{10'h0A0, 10'h01C, 10'h000, 10'h000};
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(sink_th, 10'h0A0, "sink soft reset");
    check(stop_th, 10'h01C, "stop soft reset");
    check(10'(alm_hi), 10'h000, "high alarm soft reset");
    check(10'(alm_lo), 10'h000, "low alarm soft reset");
    read_all();
    repeat (3) @(posedge ref_clk_i);
    test_done();
  end
endmodule

// *** thresh_reg.sv ***
`timescale 1ns/1ns
// One 10-bit threshold split over a low byte and a two-bit high register.
module thresh_reg #(
  parameter logic [7:0] LOW_OFS   = 8'h00,
  parameter logic [7:0] HIGH_OFS  = 8'h01,
  parameter logic [9:0] RESET_VAL = 10'h000
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       clear_i,
  input  wire supply_mon_pkg::reg_req_t   req_i,
  output logic [9:0]                      value_o
);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_o <= RESET_VAL;
    end else if (clear_i) begin
      value_o <= RESET_VAL;
    end else if (req_i.wr && req_i.addr == LOW_OFS) begin
      value_o[7:0] <= req_i.wdata;
    end else if (req_i.wr && req_i.addr == HIGH_OFS) begin
      value_o[9:8] <= req_i.wdata[1:0];
    end
  end

endmodule
